//--- core/ufic_pkg.sv
// Constants for the serial FIFO interrupt control block
package ufic_pkg;
  // Register byte offsets
  localparam logic [7:0] UFIC_CTRL_OFS = 8'h00;
  localparam logic [7:0] UFIC_IER_OFS = 8'h04;
  localparam logic [7:0] UFIC_DIV_OFS = 8'h08;
  localparam logic [7:0] UFIC_IDENT_OFS = 8'h0c;
  localparam logic [7:0] UFIC_EVT_OFS = 8'h10;
  localparam logic [7:0] UFIC_MASK_OFS = 8'h14;
  localparam logic [7:0] UFIC_LEVEL_OFS = 8'h18;
  // Control register fields
  localparam int UFIC_CTRL_FIFO_EN = 0;
  localparam int UFIC_CTRL_WLEN_LSB = 1;
  localparam int UFIC_CTRL_TWO_STOP = 3;
  localparam int UFIC_CTRL_PARITY = 4;
  localparam int UFIC_CTRL_TRIG_LSB = 5;
  // Interrupt enable bits
  localparam int UFIC_IER_RX = 0;
  localparam int UFIC_IER_TX = 1;
  localparam int UFIC_IER_LS = 2;
  localparam int UFIC_IER_MS = 3;
  // Event status bits
  localparam int UFIC_EVT_TRIG = 0;
  localparam int UFIC_EVT_TMO = 1;
  localparam int UFIC_EVT_TX_HOLDING_EMPTY_FLAG = 2;
  // Identification codes, bit 0 low means pending
  localparam logic [3:0] UFIC_ID_NONE = 4'h1;
  localparam logic [3:0] UFIC_ID_LINE = 4'h6;
  localparam logic [3:0] UFIC_ID_RXDATA = 4'h4;
  localparam logic [3:0] UFIC_ID_TMO = 4'hc;
  localparam logic [3:0] UFIC_ID_TX_HOLDING_EMPTY_FLAG = 4'h2;
  localparam logic [3:0] UFIC_ID_MODEM = 4'h0;
  localparam logic [1:0] UFIC_ID_FIFO_FLAGS = 2'h3;
  // Character timing
  localparam logic [3:0] UFIC_MIN_FRAME = 4'h7;
  localparam int UFIC_TICK_SHIFT = 4;
  localparam int UFIC_TMO_SHIFT = 2;
  // Reset values
  localparam logic [15:0] UFIC_DIV_RESET = 16'h000c;
  localparam logic [31:0] UFIC_RD_ZERO = 32'h0000_0000;
endpackage

//--- core/ufic_top.sv
// Serial FIFO interrupt control: trigger, timeout, transmit empty, polled mode, APB registers
//
// Overview of operation
// - Data-available code when fill reaches trigger
// - Timeout needs char, idle arrival, idle read
// - Second stop bit counts in character time
// - Character time runs on the baud clock
// - Read or quiet arrival restarts timeout timer
// - Receive read clears timeout and restarts timer
// - Transmit interrupts need the enable only, not FIFO mode
// - Delay empty unless two bytes were held
// - Enabling FIFO mode raises transmit interrupt at once
// - Empty code 02; cleared by write or read
// - Timeout shares priority with data available
// - Cleared enables give independent polled mode
// - Polled mode shows no timeout or trigger
// - Baud 16x clock is input over divisor
// - Timeout sets identification bits 3 and 2
// - Line status outranks data available
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ufic_top
  import ufic_pkg::*;
#(
  parameter int LW = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LW-1:0] rx_level,
  input wire logic rx_char_arrived,
  input wire logic rx_fifo_read,
  input wire logic [LW-1:0] tx_level,
  input wire logic tx_holding_write,
  input wire logic line_status_pending,
  input wire logic modem_status_pending,
  output logic baud_tick16,
  output logic serial_intr,
  output logic [7:0] interrupt_identity_reg,
  output logic irq
);

  typedef struct packed {
    logic fifo_en;
    logic [1:0] wlen;
    logic two_stop;
    logic parity_en;
    logic [LW-1:0] trig;
    logic [3:0] ier;
    logic [15:0] divisor;
    logic [2:0] evt;
    logic [2:0] mask;
    logic [31:0] rdata;
    logic [15:0] div_cnt;
    logic tick;
    logic [9:0] to_cnt;
    logic to_pend;
    logic rx_avail_q;
    logic tx_empty_q;
    logic held_two;
    logic [7:0] dly_cnt;
    logic dly_act;
    logic tx_holding_empty_flag_pend;
  } ufic_state_t;

  ufic_state_t s;
  ufic_state_t next_s;

  function automatic logic addr_ok(input logic [7:0] a);
    if (a == UFIC_CTRL_OFS) return 1'b1;
    else if (a == UFIC_IER_OFS) return 1'b1;
    else if (a == UFIC_DIV_OFS) return 1'b1;
    else if (a == UFIC_IDENT_OFS) return 1'b1;
    else if (a == UFIC_EVT_OFS) return 1'b1;
    else if (a == UFIC_MASK_OFS) return 1'b1;
    else if (a == UFIC_LEVEL_OFS) return 1'b1;
    else return 1'b0;
  endfunction

  logic setup;
  logic access;
  logic wr;
  logic rd_ident;
  logic [3:0] frame_bits;
  logic [7:0] char_ticks;
  logic [9:0] to_limit;
  logic [7:0] dly_limit;
  logic rx_avail;
  logic to_expired;
  logic to_restart;
  logic to_set;
  logic tx_empty;
  logic tx_holding_empty_flag_set;
  logic tx_holding_empty_flag_src;
  logic [3:0] id_code;
  logic [2:0] evt_in;
  logic div_tick;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite && addr_ok(paddr);
  assign rd_ident = access && !pwrite && paddr == UFIC_IDENT_OFS;

  // Frame: start, 5..8 data, optional parity, one or two stops, in 16 ticks per bit
  assign frame_bits = UFIC_MIN_FRAME + {2'b00, s.wlen} + {3'b000, s.parity_en} + {3'b000, s.two_stop};
  assign char_ticks = {frame_bits, 4'h0};
  assign to_limit = {char_ticks, 2'b00};
  assign dly_limit = 8'({4'h0, 4'(frame_bits - 4'h1)} << UFIC_TICK_SHIFT);

  // Compare is >= so a lowered divisor ticks at once instead of waiting for the count to wrap
  assign div_tick = (s.divisor != 16'h0000) && (s.div_cnt >= s.divisor - 16'h0001);

  // Polled receiver: enable bit low, nothing is indicated
  always_comb begin
    if (!s.ier[UFIC_IER_RX]) begin
      rx_avail = 1'b0;
    end else if (s.fifo_en) begin
      rx_avail = rx_level >= s.trig && rx_level != '0;
    end else begin
      rx_avail = rx_level != '0;
    end
  end

  assign to_expired = s.to_cnt == to_limit;
  assign to_restart = rx_fifo_read || (rx_char_arrived && !s.to_pend);
  assign to_set = to_expired && !to_restart && rx_level != '0 && s.fifo_en && s.ier[UFIC_IER_RX];

  assign tx_empty = tx_level == '0;
  // Empty right after a single-byte burst waits the frame less one bit; otherwise at once
  assign tx_holding_empty_flag_set = (s.dly_act && s.tick && s.dly_cnt == dly_limit && tx_empty)
      || (tx_empty && !s.tx_empty_q && s.held_two)
      || (wr && paddr == UFIC_CTRL_OFS && pwdata[UFIC_CTRL_FIFO_EN] && !s.fifo_en && tx_empty);
  assign tx_holding_empty_flag_src = s.tx_holding_empty_flag_pend && s.ier[UFIC_IER_TX];

  // Identification priority: line, receive group, transmit, modem
  always_comb begin
    if (line_status_pending && s.ier[UFIC_IER_LS]) begin
      id_code = UFIC_ID_LINE;
    end else if (s.to_pend && s.ier[UFIC_IER_RX] && s.fifo_en) begin
      id_code = UFIC_ID_TMO;
    end else if (rx_avail) begin
      id_code = UFIC_ID_RXDATA;
    end else if (tx_holding_empty_flag_src) begin
      id_code = UFIC_ID_TX_HOLDING_EMPTY_FLAG;
    end else if (modem_status_pending && s.ier[UFIC_IER_MS]) begin
      id_code = UFIC_ID_MODEM;
    end else begin
      id_code = UFIC_ID_NONE;
    end
  end

  assign evt_in = {tx_holding_empty_flag_set, to_set, rx_avail && !s.rx_avail_q};

  always_comb begin
    next_s = s;
    next_s.tick = div_tick;
    next_s.div_cnt = div_tick ? 16'h0000 : s.div_cnt + 16'h0001;
    next_s.rx_avail_q = rx_avail;
    next_s.tx_empty_q = tx_empty;
    // Timeout timer counts baud ticks and saturates at four characters
    if (to_restart) begin
      next_s.to_cnt = '0;
    end else if (s.tick && !to_expired) begin
      next_s.to_cnt = s.to_cnt + 10'h001;
    end
    if (to_set) begin
      next_s.to_pend = 1'b1;
    end else if (rx_fifo_read || rx_level == '0) begin
      next_s.to_pend = 1'b0;
    end
    // Two-byte history since the last empty indication
    if (tx_holding_empty_flag_set) begin
      next_s.held_two = 1'b0;
    end else if (tx_level >= LW'(2)) begin
      next_s.held_two = 1'b1;
    end
    if (tx_empty && !s.tx_empty_q && !s.held_two) begin
      next_s.dly_act = 1'b1;
      next_s.dly_cnt = '0;
    end else if (!tx_empty || tx_holding_empty_flag_set) begin
      next_s.dly_act = 1'b0;
    end else if (s.dly_act && s.tick) begin
      next_s.dly_cnt = s.dly_cnt + 8'h01;
    end
    // Set wins over the write and read clears
    if (tx_holding_empty_flag_set) begin
      next_s.tx_holding_empty_flag_pend = 1'b1;
    end else if (tx_holding_write || (rd_ident && id_code == UFIC_ID_TX_HOLDING_EMPTY_FLAG)) begin
      next_s.tx_holding_empty_flag_pend = 1'b0;
    end
    next_s.evt = s.evt;
    if (wr && paddr == UFIC_EVT_OFS) begin
      next_s.evt = s.evt & ~pwdata[2:0];
    end
    next_s.evt = next_s.evt | evt_in;
    if (wr) begin
      if (paddr == UFIC_CTRL_OFS) begin
        next_s.fifo_en = pwdata[UFIC_CTRL_FIFO_EN];
        next_s.wlen = pwdata[UFIC_CTRL_WLEN_LSB +: 2];
        next_s.two_stop = pwdata[UFIC_CTRL_TWO_STOP];
        next_s.parity_en = pwdata[UFIC_CTRL_PARITY];
        next_s.trig = pwdata[UFIC_CTRL_TRIG_LSB +: LW];
      end else if (paddr == UFIC_IER_OFS) begin
        next_s.ier = pwdata[3:0];
      end else if (paddr == UFIC_DIV_OFS) begin
        next_s.divisor = pwdata[15:0];
      end else if (paddr == UFIC_MASK_OFS) begin
        next_s.mask = pwdata[2:0];
      end
    end
    // Read data is captured in the setup cycle so prdata leaves a flip-flop
    if (setup) begin
      if (paddr == UFIC_CTRL_OFS) begin
        next_s.rdata = 32'({s.trig, s.parity_en, s.two_stop, s.wlen, s.fifo_en});
      end else if (paddr == UFIC_IER_OFS) begin
        next_s.rdata = {28'h0, s.ier};
      end else if (paddr == UFIC_DIV_OFS) begin
        next_s.rdata = {16'h0, s.divisor};
      end else if (paddr == UFIC_IDENT_OFS) begin
        next_s.rdata = {24'h0, interrupt_identity_reg};
      end else if (paddr == UFIC_EVT_OFS) begin
        next_s.rdata = {29'h0, s.evt};
      end else if (paddr == UFIC_MASK_OFS) begin
        next_s.rdata = {29'h0, s.mask};
      end else if (paddr == UFIC_LEVEL_OFS) begin
        next_s.rdata = {16'h0, 8'(tx_level), 8'(rx_level)};
      end else begin
        next_s.rdata = UFIC_RD_ZERO;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.divisor <= UFIC_DIV_RESET;
      s.trig <= LW'(1);
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = access;
  assign pslverr = access && !addr_ok(paddr);
  assign baud_tick16 = s.tick;
  assign interrupt_identity_reg = {s.fifo_en ? UFIC_ID_FIFO_FLAGS : 2'b00, 2'b00, id_code};
  assign serial_intr = !id_code[0];
  assign irq = |(s.evt & s.mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence tx_drained_single;
    tx_empty && !s.tx_empty_q && !s.held_two && !tx_holding_write;
  endsequence
  sequence tx_quiet_two;
    (tx_empty && !tx_holding_write && !(wr && paddr == UFIC_CTRL_OFS))[*2];
  endsequence

  a_line_beats_rx: assert property (line_status_pending && s.ier[UFIC_IER_LS] && rx_avail
      |-> interrupt_identity_reg[3:0] == UFIC_ID_LINE) else $error("line status not ranked first");
  a_polled_rx_quiet: assert property (!s.ier[UFIC_IER_RX]
      |-> id_code != UFIC_ID_RXDATA && id_code != UFIC_ID_TMO) else $error("polled receiver indicated");
  a_trig_reached: assert property (s.fifo_en && s.ier[UFIC_IER_RX] && !s.to_pend && rx_level >= s.trig
      && rx_level != '0 && !(line_status_pending && s.ier[UFIC_IER_LS])
      |-> id_code == UFIC_ID_RXDATA) else $error("trigger level not indicated");
  a_empty_drops_tmo: assert property (rx_level == '0 |=> !s.to_pend) else $error("timeout on empty FIFO");
  a_read_clears_tmo: assert property (rx_fifo_read |=> !s.to_pend && s.to_cnt == '0)
    else $error("read did not clear timeout");
  a_arrival_restart: assert property (rx_char_arrived && !s.to_pend |=> s.to_cnt == '0)
    else $error("arrival did not restart timer");
  a_tmo_needs_time: assert property ($rose(s.to_pend) |-> $past(s.to_cnt) == $past(to_limit))
    else $error("timeout before four characters");
  a_fifo_on_tx_holding_empty_flag: assert property (wr && paddr == UFIC_CTRL_OFS && pwdata[UFIC_CTRL_FIFO_EN] && !s.fifo_en
      && tx_empty |=> s.tx_holding_empty_flag_pend) else $error("no immediate transmit interrupt");
  a_single_delays: assert property (tx_drained_single ##1 tx_quiet_two |-> !s.tx_holding_empty_flag_pend || $past(s.tx_holding_empty_flag_pend, 2))
    else $error("empty not delayed");
  a_tx_holding_empty_flag_write_clr: assert property (tx_holding_write && !tx_holding_empty_flag_set |=> !s.tx_holding_empty_flag_pend)
    else $error("write did not clear empty");
  a_baud_period: assert property (s.tick && s.divisor == 16'h0003 ##1 $stable(s.divisor)[*3] |-> s.tick)
    else $error("baud tick period wrong");
endmodule
`default_nettype wire

//--- testbench/ufic_host_model.sv
// Host-side model of the receive and transmit FIFO fill levels
`timescale 1ns/1ps
`default_nettype none
module ufic_host_model #(
  parameter int LW = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic tx_pop,
  output logic [LW-1:0] rx_level,
  output logic rx_char_arrived,
  output logic rx_fifo_read,
  output logic [LW-1:0] tx_level,
  output logic tx_holding_write
);
  // Pulse and level move on the same edge, as a real FIFO does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_level <= '0;
      tx_level <= '0;
      rx_char_arrived <= 1'b0;
      rx_fifo_read <= 1'b0;
      tx_holding_write <= 1'b0;
    end else begin
      rx_char_arrived <= rx_push;
      rx_fifo_read <= rx_pop && rx_level != '0;
      rx_level <= rx_level + LW'(rx_push) - LW'(rx_pop && rx_level != '0);
      tx_holding_write <= tx_push;
      tx_level <= tx_level + LW'(tx_push) - LW'(tx_pop && tx_level != '0);
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the serial FIFO interrupt control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ufic_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, line_pend = 0;
  logic rx_push = 0, rx_pop = 0, tx_push = 0, tx_pop = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, rx_arr, rx_rd, tx_wr, serial_intr, irq, tick16;
  logic [4:0] rx_level, tx_level;
  logic [7:0] ident;
  int error_cnt = 0, checks = 0, tick_cnt = 0;
  // Write, offset, write data, expected read, expected error
  logic [73:0] rows [11] = '{
    {1'b0, UFIC_CTRL_OFS, 32'h0, 32'h20, 1'b0}, {1'b0, UFIC_IER_OFS, 32'h0, 32'h0, 1'b0},
    {1'b0, UFIC_DIV_OFS, 32'h0, 32'hc, 1'b0}, {1'b0, UFIC_MASK_OFS, 32'h0, 32'h0, 1'b0},
    {1'b0, 8'h1c, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h1c, 32'hff, 32'h0, 1'b1},
    // Divisor 1 keeps character times short
    {1'b1, UFIC_DIV_OFS, 32'h1, 32'h0, 1'b0}, {1'b1, UFIC_CTRL_OFS, 32'h87, 32'h0, 1'b0},
    {1'b0, UFIC_CTRL_OFS, 32'h0, 32'h87, 1'b0}, {1'b1, UFIC_IER_OFS, 32'h1, 32'h0, 1'b0},
    {1'b0, UFIC_IER_OFS, 32'h0, 32'h1, 1'b0}};

  ufic_top #(.LW(5)) u_ufic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_level(rx_level), .rx_char_arrived(rx_arr), .rx_fifo_read(rx_rd),
    .tx_level(tx_level), .tx_holding_write(tx_wr), .line_status_pending(line_pend),
    .modem_status_pending(1'b0), .baud_tick16(tick16), .serial_intr(serial_intr),
    .interrupt_identity_reg(ident), .irq(irq));

  ufic_host_model #(.LW(5)) u_ufic_host_model (.pclk(pclk), .presetn(presetn), .rx_push(rx_push),
    .rx_pop(rx_pop), .tx_push(tx_push), .tx_pop(tx_pop), .rx_level(rx_level),
    .rx_char_arrived(rx_arr), .rx_fifo_read(rx_rd), .tx_level(tx_level), .tx_holding_write(tx_wr));

  initial begin
    forever #5 pclk = ~pclk;
  end

  task stop_test;
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      stop_test;
    end
  endtask

  // Kinds: 0 receive push, 1 receive read, 2 transmit write, 3 transmit drain
  task ev(input int k);
    @(posedge pclk);
    rx_push <= k == 0;
    rx_pop <= k == 1;
    tx_push <= k == 2;
    tx_pop <= k == 3;
    @(posedge pclk);
    {rx_push, rx_pop, tx_push, tx_pop} <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask

  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task cid(input logic [7:0] x);
    #1;
    chk(32'(ident), 32'(x));
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
      if (!rows[i][73]) chk(rd, rows[i][32:1]);
      chk(32'(er), 32'(rows[i][0]));
    end
    repeat (3) ev(0);
    cid(8'hc1);
    ev(0);
    cid(8'hc4);
    ev(1);
    cid(8'hc1);
    idle(590);
    cid(8'hc1);
    idle(80);
    cid(8'hcc);
    ev(1);
    cid(8'hc1);
    apb(1'b1, UFIC_CTRL_OFS, 32'h8f);
    idle(660);
    cid(8'hc1);
    idle(80);
    cid(8'hcc);
    ev(1);
    ev(1);
    idle(800);
    cid(8'hc1);
    repeat (4) ev(0);
    cid(8'hc4);
    @(posedge pclk);
    line_pend <= 1'b1;
    apb(1'b1, UFIC_IER_OFS, 32'h5);
    cid(8'hc6);
    @(posedge pclk);
    line_pend <= 1'b0;
    apb(1'b1, UFIC_IER_OFS, 32'h0);
    idle(800);
    cid(8'hc1);
    apb(1'b1, UFIC_IER_OFS, 32'h2);
    cid(8'hc2);
    apb(1'b0, UFIC_IDENT_OFS, 32'h0);
    chk(rd, 32'hc2);
    cid(8'hc1);
    ev(2);
    ev(3);
    idle(100);
    cid(8'hc1);
    idle(80);
    cid(8'hc2);
    ev(2);
    cid(8'hc1);
    ev(2);
    ev(3);
    ev(3);
    cid(8'hc2);
    chk(32'(serial_intr), 32'h1);
    apb(1'b1, UFIC_MASK_OFS, 32'h4);
    #1;
    chk(32'(irq), 32'h1);
    apb(1'b1, UFIC_EVT_OFS, 32'h4);
    #1;
    chk(32'(irq), 32'h0);
    apb(1'b1, UFIC_MASK_OFS, 32'h0);
    ev(2);
    ev(3);
    idle(200);
    chk(32'(irq), 32'h0);
    // Mid-run reset: everything returns to its reset value
    presetn <= 1'b0;
    idle(3);
    #1;
    chk(prdata, UFIC_RD_ZERO);
    chk(32'(ident), 32'h01);
    chk(32'(irq), 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, UFIC_DIV_OFS, 32'h0);
    chk(rd, 32'hc);
    apb(1'b0, UFIC_CTRL_OFS, 32'h0);
    chk(rd, 32'h20);
    // Divisor 3 gives ten ticks in any thirty cycles
    apb(1'b1, UFIC_DIV_OFS, 32'h3);
    repeat (30) begin
      @(posedge pclk);
      #1;
      tick_cnt += int'(tick16);
    end
    chk(32'(tick_cnt), 32'ha);
    stop_test;
  end
endmodule
`default_nettype wire
